// *** common/armms_pkg.sv ***
`default_nettype none
package armms_pkg;
  // Clock and timing base
  localparam int CLK_PERIOD_NS = 25;
  localparam int EXT_CLK_NOM_KHZ = 12288;
  localparam int STARTUP_US = 10;
  localparam int STARTUP_CYC =
    (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MS = 1000;
  localparam int SETTLE_CYC_DEF = SETTLE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SOFT_US = 1000;
  localparam int SOFT_CYC_DEF =
    (SOFT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_US = 100;
  localparam int SHORT_CYC_DEF =
    (SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

  // Field positions
  localparam int CTRL_FMUTE_BIT = 0;
  localparam int STAT_MONO_BIT = 3;
  localparam int STAT_OCN_BIT = 4;
  localparam int STAT_EARLY_BIT = 5;
  localparam int IRQ_W = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_RUN = 1;
  localparam int IRQ_OC = 2;
  localparam int IRQ_EARLY = 3;

  // Reset values
  localparam logic CTRL_FMUTE_RST = 1'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // Modulator loop order
  localparam logic [2:0] ORDER_HIGH = 3'h7;
  localparam logic [2:0] ORDER_LOW = 3'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_STARTUP,
    ST_MUTED,
    ST_SOFT,
    ST_RUN,
    ST_FAULT
  } armms_state_t;
endpackage
`default_nettype wire

// *** hw/armms_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module armms_clkdiv
  import armms_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ext_clk_i,
  input wire logic run_i,
  output logic sample_clk_o
);
  typedef struct packed {
    logic ext_prev;
    logic div;
  } armms_div_t;

  armms_div_t r;
  armms_div_t n;

  // Toggle per input clock rise gives half rate
  always_comb begin
    n = r;
    n.ext_prev = ext_clk_i;
    // RULE_11: halve input clock
    // RULE_12: any rate below half CLK_I works
    if (!run_i) begin
      n.div = 1'b0;
    end else if (ext_clk_i && !r.ext_prev) begin
      n.div = !r.div;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sample_clk_o = r.div;

  property p_half_rate;
    @(posedge clk_i) disable iff (!nrst_i)
    run_i && ext_clk_i && !r.ext_prev |=>
      sample_clk_o != $past(sample_clk_o);
  endproperty
  a_half_rate: assert property (p_half_rate) // RULE_11
    else $error("sample clock missed an input edge");
endmodule
`default_nettype wire

// *** hw/armms_top.sv ***
// Contract
// RULE_01: While the amp reset pin is low the modulator is halted and both stages are tristated.
// RULE_02: Releasing the amp reset starts a start-up sequence before anything else.
// RULE_03: After start-up the modulator runs but the stages stay undriven until unmute.
// RULE_04: Unmute starts driving the stages through a soft-start phase.
// RULE_05: While mute is asserted the output transistors never switch.
// RULE_06: The host holds reset and mute low until supplies settle, then raises reset.
// RULE_07: The host should release mute at least one second after the reset rise.
// RULE_08: An early unmute still gives audio, through a shorter soft-start.
// RULE_09: Mono select is sampled at the reset rise; mono disables the right modulator.
// RULE_10: In mono the right feedback inputs are ignored.
// RULE_11: The sample clock runs at half the external input clock.
// RULE_12: The input clock may be 12.288 MHz nominal within ten percent.
// RULE_13: The loop is seventh order and drops to second order above threshold.
// RULE_14: Overcurrent enters an error state that stops output switching.
// RULE_15: The overcurrent error is shown by driving the error flag low.
// RULE_16: The latched mono value holds until the next amp reset.
`timescale 1ns/1ps
`default_nettype none
module armms_top
  import armms_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF,
  parameter int SOFT_CYC = SOFT_CYC_DEF,
  parameter int SHORT_CYC = SHORT_CYC_DEF
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [3:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [3:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic AMP_RESET_N_I,
  input wire logic MUTE_N_I,
  input wire logic MONO_SEL_I,
  input wire logic EXT_CLK_I,
  input wire logic OVERCURRENT_I,
  input wire logic MOD_OVER_THRESH_I,
  input wire logic RIGHT_FEEDBACK_POS_I,
  input wire logic RIGHT_FEEDBACK_NEG_I,
  output logic MOD_RUN_O,
  output logic MOD_RIGHT_EN_O,
  output logic MONO_O,
  output logic [1:0] STAGE_OE_N_O,
  output logic SOFT_ACTIVE_O,
  output logic SAMPLE_CLK_O,
  output logic [2:0] MOD_ORDER_O,
  output logic RIGHT_FB_POS_O,
  output logic RIGHT_FB_NEG_O,
  output logic OVERCURRENT_FLAG_N_O,
  output logic IRQ_O
);
  localparam int CW = $clog2(SETTLE_CYC + SOFT_CYC + SHORT_CYC + 1);

  typedef struct packed {
    armms_state_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] settle;
    logic amp_prev;
    logic mono;
    logic early;
    logic [2:0] order;
    logic fb_pos;
    logic fb_neg;
    logic fmute;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic wen0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } armms_regs_t;

  localparam armms_regs_t REGS_RST = '{
    st: ST_RESET,
    order: ORDER_HIGH,
    fmute: CTRL_FMUTE_RST,
    irq_mask: IRQ_MASK_RST,
    default: '0
  };

  armms_regs_t r;
  armms_regs_t n;
  logic mute_act;
  logic go;
  logic early_now;
  logic settled;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic driving;

  // Mapped offsets, shared by read and write paths
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
              (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction

  // Software mute and the mute pin each force mute; neither can unmute the other
  assign mute_act = !MUTE_N_I || r.fmute;
  assign go = AMP_RESET_N_I && !OVERCURRENT_I && !mute_act;
  assign settled = (r.settle == CW'(SETTLE_CYC));
  assign early_now = !settled;

  // Next state of sequencer, pins and register file
  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    n.amp_prev = AMP_RESET_N_I;
    // RULE_09: latch mono at reset rise
    // RULE_16: held until next rise only
    if (AMP_RESET_N_I && !r.amp_prev) begin
      n.mono = MONO_SEL_I;
    end
    // Time since reset rise, saturating
    if (!AMP_RESET_N_I) begin
      n.settle = '0;
    end else if (!settled) begin
      n.settle = r.settle + 1'b1;
    end
    // RULE_10: drop right feedback in mono
    n.fb_pos = !r.mono && RIGHT_FEEDBACK_POS_I;
    n.fb_neg = !r.mono && RIGHT_FEEDBACK_NEG_I;
    // RULE_13: order reduction above threshold
    n.order = MOD_OVER_THRESH_I ? ORDER_LOW : ORDER_HIGH;
    if (r.cnt != '0) begin
      n.cnt = r.cnt - 1'b1;
    end
    // RULE_01: reset pin forces quiet state
    if (!AMP_RESET_N_I) begin
      n.st = ST_RESET;
      n.early = 1'b0;
      n.cnt = '0;
    // RULE_14: overcurrent stops switching
    end else if (OVERCURRENT_I && r.st != ST_FAULT) begin
      n.st = ST_FAULT;
      ev[IRQ_OC] = 1'b1;
    end else begin
      unique case (r.st)
        // RULE_02: start-up after release
        ST_RESET: begin
          n.st = ST_STARTUP;
          n.cnt = CW'(STARTUP_CYC);
        end
        // RULE_03: wait muted after start-up
        ST_STARTUP: begin
          if (r.cnt == '0) begin
            n.st = ST_MUTED;
            ev[IRQ_START] = 1'b1;
          end
        end
        // RULE_04: unmute starts soft-start
        // RULE_08: early unmute uses short ramp
        ST_MUTED: begin
          if (!mute_act) begin
            n.st = ST_SOFT;
            n.early = early_now;
            n.cnt = early_now ? CW'(SHORT_CYC) : CW'(SOFT_CYC);
            ev[IRQ_EARLY] = early_now;
          end
        end
        // RULE_05: mute stops switching at once
        ST_SOFT: begin
          if (mute_act) begin
            n.st = ST_MUTED;
          end else if (r.cnt == '0) begin
            n.st = ST_RUN;
            ev[IRQ_RUN] = 1'b1;
          end
        end
        ST_RUN: begin
          if (mute_act) begin
            n.st = ST_MUTED;
          end
        end
        // Fault is left only through the reset pin
        ST_FAULT: begin
          n.st = ST_FAULT;
        end
        default: begin
          n.st = ST_RESET;
        end
      endcase
    end
    // Write channel: response drained before new items
    if (r.bvalid && BREADY_I) begin
      n.bvalid = 1'b0;
    end
    if (AWVALID_I && AWREADY_O) begin
      n.aw_got = 1'b1;
      n.awaddr = AWADDR_I;
    end
    if (WVALID_I && WREADY_O) begin
      n.w_got = 1'b1;
      n.wdata = WDATA_I;
      n.wen0 = WSTRB_I[0];
    end
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_ok(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (r.wen0 && r.awaddr == ADDR_CTRL) begin
        n.fmute = r.wdata[CTRL_FMUTE_BIT];
      end
      if (r.wen0 && r.awaddr == ADDR_IRQ_STAT) begin
        clr = r.wdata[IRQ_W-1:0];
      end
      if (r.wen0 && r.awaddr == ADDR_IRQ_MASK) begin
        n.irq_mask = r.wdata[IRQ_W-1:0];
      end
    end
    // Sticky events: a new event beats a same-cycle clear
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    // Read channel, one cycle latency
    if (r.rvalid && RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID_I && ARREADY_O) begin
      n.rvalid = 1'b1;
      n.rresp = addr_ok(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      n.rdata = '0;
      unique case (ARADDR_I)
        ADDR_CTRL: n.rdata[CTRL_FMUTE_BIT] = r.fmute;
        ADDR_STATUS: begin
          n.rdata[2:0] = r.st;
          n.rdata[STAT_MONO_BIT] = r.mono;
          n.rdata[STAT_OCN_BIT] = r.st != ST_FAULT;
          n.rdata[STAT_EARLY_BIT] = r.early;
        end
        ADDR_IRQ_STAT: n.rdata[IRQ_W-1:0] = r.irq_stat;
        ADDR_IRQ_MASK: n.rdata[IRQ_W-1:0] = r.irq_mask;
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  // Half-rate sample clock, stopped while halted
  armms_clkdiv armms_clkdiv_i (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .ext_clk_i(EXT_CLK_I),
    .run_i(MOD_RUN_O),
    .sample_clk_o(SAMPLE_CLK_O)
  );

  // Bus handshakes, one transaction in flight per channel
  assign AWREADY_O = !r.aw_got && !r.bvalid;
  assign WREADY_O = !r.w_got && !r.bvalid;
  assign BVALID_O = r.bvalid;
  assign BRESP_O = r.bresp;
  assign ARREADY_O = !r.rvalid;
  assign RVALID_O = r.rvalid;
  assign RDATA_O = r.rdata;
  assign RRESP_O = r.rresp;

  // Pin decode from state flops
  assign driving = (r.st == ST_SOFT) || (r.st == ST_RUN);
  assign MOD_RUN_O = (r.st == ST_MUTED) || driving || (r.st == ST_FAULT);
  assign MOD_RIGHT_EN_O = MOD_RUN_O && !r.mono;
  assign MONO_O = r.mono;
  // Mono still drives both stages, from the left loop
  assign STAGE_OE_N_O = driving ? 2'h0 : 2'h3;
  assign SOFT_ACTIVE_O = (r.st == ST_SOFT);
  assign MOD_ORDER_O = r.order;
  assign RIGHT_FB_POS_O = r.fb_pos;
  assign RIGHT_FB_NEG_O = r.fb_neg;
  // RULE_15: flag low in error state
  assign OVERCURRENT_FLAG_N_O = (r.st != ST_FAULT);
  assign IRQ_O = |(r.irq_stat & r.irq_mask);

  property p_reset_quiet;
    @(posedge CLK_I) disable iff (!NRST_I)
    !AMP_RESET_N_I |=> STAGE_OE_N_O == 2'h3 && !MOD_RUN_O;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) // RULE_01
    else $error("stage active while amp reset low");

  property p_startup;
    @(posedge CLK_I) disable iff (!NRST_I)
    $rose(AMP_RESET_N_I) && !OVERCURRENT_I |=>
      r.st == ST_STARTUP ##1 r.cnt == CW'(STARTUP_CYC) - 1'b1;
  endproperty
  a_startup: assert property (p_startup) // RULE_02
    else $error("start-up not begun after reset release");

  property p_muted_idle;
    @(posedge CLK_I) disable iff (!NRST_I)
    r.st == ST_MUTED |-> MOD_RUN_O && STAGE_OE_N_O == 2'h3;
  endproperty
  a_muted_idle: assert property (p_muted_idle) // RULE_03
    else $error("muted state drives stages or halts loop");

  property p_unmute;
    @(posedge CLK_I) disable iff (!NRST_I)
    r.st == ST_MUTED && go |=> SOFT_ACTIVE_O && STAGE_OE_N_O == 2'h0;
  endproperty
  a_unmute: assert property (p_unmute) // RULE_04
    else $error("unmute did not start soft-start");

  property p_mute_hold;
    @(posedge CLK_I) disable iff (!NRST_I)
    !MUTE_N_I |=> STAGE_OE_N_O == 2'h3;
  endproperty
  a_mute_hold: assert property (p_mute_hold) // RULE_05
    else $error("stage driven while mute asserted");

  property p_early;
    @(posedge CLK_I) disable iff (!NRST_I)
    r.st == ST_MUTED && go && !settled |=>
      r.early && r.cnt == CW'(SHORT_CYC);
  endproperty
  a_early: assert property (p_early) // RULE_08
    else $error("early unmute did not pick short ramp");

  property p_mono_latch;
    @(posedge CLK_I) disable iff (!NRST_I)
    AMP_RESET_N_I && !r.amp_prev |=> MONO_O == $past(MONO_SEL_I);
  endproperty
  a_mono_latch: assert property (p_mono_latch) // RULE_09
    else $error("mono select not latched at reset rise");

  property p_mono_hold;
    @(posedge CLK_I) disable iff (!NRST_I)
    AMP_RESET_N_I && $past(AMP_RESET_N_I) && $past(AMP_RESET_N_I, 2)
      |-> $stable(MONO_O);
  endproperty
  a_mono_hold: assert property (p_mono_hold) // RULE_16
    else $error("mono changed while out of reset");

  property p_mono_fb;
    @(posedge CLK_I) disable iff (!NRST_I)
    MONO_O |=> !RIGHT_FB_POS_O && !RIGHT_FB_NEG_O && !MOD_RIGHT_EN_O;
  endproperty
  a_mono_fb: assert property (p_mono_fb) // RULE_10
    else $error("right loop active in mono");

  property p_order;
    @(posedge CLK_I) disable iff (!NRST_I)
    MOD_OVER_THRESH_I |=> MOD_ORDER_O == ORDER_LOW;
  endproperty
  a_order: assert property (p_order) // RULE_13
    else $error("order not reduced above threshold");

  property p_overcurrent;
    @(posedge CLK_I) disable iff (!NRST_I)
    AMP_RESET_N_I && OVERCURRENT_I ##1 AMP_RESET_N_I |->
      (!OVERCURRENT_FLAG_N_O && STAGE_OE_N_O == 2'h3) [*2];
  endproperty
  a_overcurrent: assert property (p_overcurrent) // RULE_14
    else $error("overcurrent did not stop switching");
endmodule
`default_nettype wire

// *** testbench/armms_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module armms_host (
  input wire logic clk_i,
  output logic amp_reset_n_o,
  output logic mute_n_o,
  output logic mono_sel_o
);
  int since_rise = 0;
  initial begin
    amp_reset_n_o = 1'h0;
    mute_n_o = 1'h0;
    mono_sel_o = 1'h0;
  end
  // Cycles since the host released reset
  always @(posedge clk_i) begin
    since_rise <= amp_reset_n_o ? since_rise + 1 : 0;
  end
  task hold_reset();
    @(posedge clk_i);
    amp_reset_n_o <= 1'h0;
    mute_n_o <= 1'h0;
  endtask
  task release_reset(input logic mono);
    @(posedge clk_i);
    mono_sel_o <= mono;
    @(posedge clk_i);
    amp_reset_n_o <= 1'h1;
  endtask
  task unmute(input int min_wait);
    while (since_rise < min_wait) @(posedge clk_i);
    @(posedge clk_i);
    mute_n_o <= 1'h1;
  endtask
  task set_mute();
    @(posedge clk_i);
    mute_n_o <= 1'h0;
  endtask
  // Late pin change, must not reach the mode
  task set_mono(input logic v);
    @(posedge clk_i);
    mono_sel_o <= v;
  endtask
endmodule
`default_nettype wire

// *** testbench/armms_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module armms_top_tb;
  import armms_pkg::*;
  // Short counts keep the run small
  localparam int SETTLE = 1000;
  localparam int SOFT = 50;
  localparam int SHORT = 10;
  logic CLK_I = 1'h0;
  logic NRST_I = 1'h0;
  logic [3:0] AWADDR_I = 4'h0;
  logic [3:0] ARADDR_I = 4'h0;
  logic [3:0] WSTRB_I = 4'h0;
  logic [31:0] WDATA_I = 32'h0;
  logic AWVALID_I = 1'h0;
  logic WVALID_I = 1'h0;
  logic BREADY_I = 1'h0;
  logic ARVALID_I = 1'h0;
  logic RREADY_I = 1'h0;
  logic EXT_CLK_I = 1'h0;
  logic OVERCURRENT_I = 1'h0;
  logic MOD_OVER_THRESH_I = 1'h0;
  logic RIGHT_FEEDBACK_POS_I = 1'h0;
  logic RIGHT_FEEDBACK_NEG_I = 1'h0;
  logic AMP_RESET_N_I, MUTE_N_I, MONO_SEL_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0] BRESP_O, RRESP_O, STAGE_OE_N_O;
  logic [31:0] RDATA_O;
  logic MOD_RUN_O, MOD_RIGHT_EN_O, MONO_O, SOFT_ACTIVE_O, SAMPLE_CLK_O;
  logic [2:0] MOD_ORDER_O;
  logic RIGHT_FB_POS_O, RIGHT_FB_NEG_O, OVERCURRENT_FLAG_N_O, IRQ_O;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares = 0;
  int n_compared = 0;
  int ext_inc = 6144;
  int ext_acc = 0;
  int ext_rises = 0;

  armms_top #(.SETTLE_CYC(SETTLE), .SOFT_CYC(SOFT), .SHORT_CYC(SHORT))
  armms_top_i (.CLK_I, .NRST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
    .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
    .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
    .RVALID_O, .RREADY_I, .AMP_RESET_N_I, .MUTE_N_I, .MONO_SEL_I,
    .EXT_CLK_I, .OVERCURRENT_I, .MOD_OVER_THRESH_I, .RIGHT_FEEDBACK_POS_I,
    .RIGHT_FEEDBACK_NEG_I, .MOD_RUN_O, .MOD_RIGHT_EN_O, .MONO_O,
    .STAGE_OE_N_O, .SOFT_ACTIVE_O, .SAMPLE_CLK_O, .MOD_ORDER_O,
    .RIGHT_FB_POS_O, .RIGHT_FB_NEG_O, .OVERCURRENT_FLAG_N_O, .IRQ_O);

  armms_host armms_host_i (.clk_i(CLK_I), .amp_reset_n_o(AMP_RESET_N_I),
    .mute_n_o(MUTE_N_I), .mono_sel_o(MONO_SEL_I));

  // System clock, 40 MHz
  initial forever #12.5 CLK_I = ~CLK_I;

  // Fractional step keeps the audio clock off the system grid
  always @(posedge CLK_I) begin
    ext_acc = ext_acc + ext_inc;
    if (ext_acc >= 10000) begin
      ext_acc = ext_acc - 10000;
      EXT_CLK_I <= ~EXT_CLK_I;
      if (EXT_CLK_I == 1'h0) ext_rises++;
    end
  end

  task close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %0h got %0h", n, e, g);
    end
  endtask

  // Look one step after the edge so its updates have landed
  task tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task axw(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, dn;
    dn = 1'h0;
    @(posedge CLK_I);
    AWADDR_I <= a;
    AWVALID_I <= 1'h1;
    WDATA_I <= v;
    WSTRB_I <= 4'hF;
    WVALID_I <= 1'h1;
    BREADY_I <= 1'h1;
    // Only the watchdog ends a wait for the response
    while (!dn) begin
      #1;
      ta = AWVALID_I & AWREADY_O;
      tw = WVALID_I & WREADY_O;
      dn = BVALID_O === 1'h1;
      r = BRESP_O;
      @(posedge CLK_I);
      if (ta === 1'h1) AWVALID_I <= 1'h0;
      if (tw === 1'h1) WVALID_I <= 1'h0;
      if (dn) BREADY_I <= 1'h0;
    end
  endtask

  task rdc(input string n, input logic [3:0] a, input logic [31:0] e,
           input logic [1:0] er);
    logic ta, dn;
    dn = 1'h0;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'h1;
    RREADY_I <= 1'h1;
    while (!dn) begin
      #1;
      ta = ARVALID_I & ARREADY_O;
      dn = RVALID_O === 1'h1;
      d = RDATA_O;
      r = RRESP_O;
      @(posedge CLK_I);
      if (ta === 1'h1) ARVALID_I <= 1'h0;
      if (dn) RREADY_I <= 1'h0;
    end
    chk(n, e, d);
    chk(n, er, r);
  endtask

  task t_idle();
    tick(1);
    chk("oe", 32'h3, STAGE_OE_N_O);
    chk("run", 32'h0, MOD_RUN_O);
    chk("sclk", 32'h0, SAMPLE_CLK_O);
    chk("flag", 32'h1, OVERCURRENT_FLAG_N_O);
    rdc("ctrl", ADDR_CTRL, 32'h0, RESP_OKAY);
    rdc("unmapped", 4'h2, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'hFF);
    chk("ro_resp", RESP_OKAY, r);
    axw(4'h2, 32'h1);
    chk("unmapped_w", RESP_SLVERR, r);
    rdc("status", ADDR_STATUS, 32'h10, RESP_OKAY);
  endtask

  task t_up(input logic mono);
    int i;
    armms_host_i.release_reset(mono);
    tick(1);
    chk("start_oe", 32'h3, STAGE_OE_N_O);
    chk("start_run", 32'h0, MOD_RUN_O);
    for (i = 0; i < 1000 && MOD_RUN_O !== 1'h1; i++) tick(1);
    chk("muted_run", 32'h1, MOD_RUN_O);
    chk("muted_oe", 32'h3, STAGE_OE_N_O);
    chk("mono", mono, MONO_O);
    chk("right_en", !mono, MOD_RIGHT_EN_O);
  endtask

  task t_irq();
    rdc("irq_start", ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    chk("irq_masked", 32'h0, IRQ_O);
    axw(ADDR_IRQ_MASK, 32'h1);
    tick(1);
    chk("irq_on", 32'h1, IRQ_O);
    axw(ADDR_IRQ_STAT, 32'h1);
    tick(1);
    chk("irq_clr", 32'h0, IRQ_O);
  endtask

  // Counts the cycles spent in soft-start
  task soft_run(input int exp);
    int i, n;
    n = 0;
    // A bus write may already have started the ramp at this edge
    #1;
    for (i = 0; i < 20 && SOFT_ACTIVE_O !== 1'h1; i++) tick(1);
    chk("soft_oe", 32'h0, STAGE_OE_N_O);
    while (SOFT_ACTIVE_O === 1'h1 && n < 2000) begin
      n++;
      tick(1);
    end
    chk("soft_len", exp, n);
    chk("run_oe", 32'h0, STAGE_OE_N_O);
  endtask

  task t_early();
    armms_host_i.unmute(0);
    soft_run(SHORT + 1);
    rdc("st_early", ADDR_STATUS, 32'h34, RESP_OKAY);
    rdc("irq_run", ADDR_IRQ_STAT, 32'hA, RESP_OKAY);
    axw(ADDR_IRQ_STAT, 32'hF);
    rdc("irq_w1c", ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
  endtask

  task t_mute();
    armms_host_i.set_mute();
    tick(1);
    chk("mute_oe", 32'h3, STAGE_OE_N_O);
    tick(20);
    chk("mute_hold", 32'h3, STAGE_OE_N_O);
    armms_host_i.unmute(SETTLE + 2);
    soft_run(SOFT + 1);
    axw(ADDR_CTRL, 32'h1);
    tick(1);
    chk("fmute_oe", 32'h3, STAGE_OE_N_O);
    axw(ADDR_CTRL, 32'h0);
    soft_run(SOFT + 1);
  endtask

  task t_fb(input logic mono);
    int v;
    for (v = 0; v < 2; v++) begin
      @(posedge CLK_I);
      RIGHT_FEEDBACK_POS_I <= v[0];
      RIGHT_FEEDBACK_NEG_I <= !v[0];
      tick(1);
      chk("fb_pos", v[0] & !mono, RIGHT_FB_POS_O);
      chk("fb_neg", !v[0] & !mono, RIGHT_FB_NEG_O);
    end
  endtask

  task t_order();
    @(posedge CLK_I);
    MOD_OVER_THRESH_I <= 1'h1;
    tick(1);
    chk("order_lo", ORDER_LOW, MOD_ORDER_O);
    @(posedge CLK_I);
    MOD_OVER_THRESH_I <= 1'h0;
    tick(1);
    chk("order_hi", ORDER_HIGH, MOD_ORDER_O);
  endtask

  // Nominal rate and both ends of the tolerance band
  task t_clk();
    int k, i, e0, s, dv;
    int incs[3] = '{5530, 6144, 6758};
    logic p;
    for (k = 0; k < 3; k++) begin
      @(posedge CLK_I);
      ext_inc <= incs[k];
      tick(50);
      e0 = ext_rises;
      s = 0;
      p = SAMPLE_CLK_O;
      for (i = 0; i < 400; i++) begin
        tick(1);
        if (SAMPLE_CLK_O === 1'h1 && p === 1'h0) s++;
        p = SAMPLE_CLK_O;
      end
      dv = 2 * s - (ext_rises - e0);
      chk("half_rate", 32'h1, dv >= -2 && dv <= 2);
    end
  endtask

  task t_oc();
    axw(ADDR_IRQ_STAT, 32'hF);
    @(posedge CLK_I);
    OVERCURRENT_I <= 1'h1;
    tick(1);
    chk("oc_flag", 32'h0, OVERCURRENT_FLAG_N_O);
    chk("oc_oe", 32'h3, STAGE_OE_N_O);
    @(posedge CLK_I);
    OVERCURRENT_I <= 1'h0;
    tick(5);
    chk("oc_stay", 32'h0, OVERCURRENT_FLAG_N_O);
    rdc("irq_oc", ADDR_IRQ_STAT, 32'h4, RESP_OKAY);
    armms_host_i.hold_reset();
    tick(1);
    chk("rst_oe", 32'h3, STAGE_OE_N_O);
    chk("rst_run", 32'h0, MOD_RUN_O);
    chk("rst_flag", 32'h1, OVERCURRENT_FLAG_N_O);
  endtask

  task t_mono();
    t_up(1'h1);
    armms_host_i.set_mono(1'h0);
    tick(3);
    chk("mono_hold", 32'h1, MONO_O);
    t_fb(1'h1);
    armms_host_i.unmute(0);
    soft_run(SHORT + 1);
    chk("mono_right", 32'h0, MOD_RIGHT_EN_O);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge CLK_I);
    NRST_I <= 1'h1;
    t_idle();
    t_up(1'h0);
    t_irq();
    t_early();
    t_mute();
    t_fb(1'h0);
    t_order();
    t_clk();
    t_oc();
    t_mono();
    close_out();
  end

  // Run needs about 3000 cycles; over six times that means a hang
  initial begin
    #(25 * 20000);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
